// [shared/pmf_pkg.sv]
// package: register map, field layout, message codes and carriers for the ptp message filter
package pmf_pkg;

	////////////////////////////////////////////////////////////////////////
	// register indices; byte address is four times the index
	localparam logic [13:0] PMF_IDX_MSG_CFG2 = 14'h0516;
	localparam logic [13:0] PMF_IDX_DOM_VER  = 14'h0518;
	localparam logic [13:0] PMF_IDX_VER_EXC  = 14'h051a;
	localparam logic [13:0] PMF_IDX_STATUS   = 14'h051c;
	localparam int unsigned PMF_ADDR_W       = 16;
	localparam int unsigned PMF_DATA_W       = 32;
	localparam int unsigned PMF_REG_W        = 16;

	////////////////////////////////////////////////////////////////////////
	// message config two fields
	localparam int unsigned PMF_BIT_RESP_PAIR = 8;
	localparam int unsigned PMF_BIT_PEER_PAIR = 7;
	localparam int unsigned PMF_BIT_DROP_NOBM = 5;
	localparam int unsigned PMF_BIT_DOM_CHK   = 4;
	localparam int unsigned PMF_BIT_CSUM_V4   = 2;
	localparam logic [15:0] PMF_CFG2_RST      = 16'h0004;
	localparam logic [15:0] PMF_CFG2_WMASK    = 16'h01ff;

	////////////////////////////////////////////////////////////////////////
	// domain and version fields
	localparam int unsigned PMF_VER_LSB   = 8;
	localparam int unsigned PMF_VER_W     = 4;
	localparam int unsigned PMF_DOM_LSB   = 0;
	localparam int unsigned PMF_DOM_W     = 8;
	localparam logic [15:0] PMF_DV_RST    = 16'h0200;
	localparam logic [15:0] PMF_DV_WMASK  = 16'h0fff;
	localparam logic [15:0] PMF_EXC_RST   = 16'h0000;

	////////////////////////////////////////////////////////////////////////
	// message type codes
	localparam logic [3:0] PMF_MT_SYNC      = 4'h0;
	localparam logic [3:0] PMF_MT_DLY_REQ   = 4'h1;
	localparam logic [3:0] PMF_MT_PDLY_REQ  = 4'h2;
	localparam logic [3:0] PMF_MT_PDLY_RESP = 4'h3;
	localparam logic [3:0] PMF_MT_FOLLOW_UP = 4'h8;
	localparam logic [3:0] PMF_MT_DLY_RESP  = 4'h9;
	localparam logic [3:0] PMF_MT_PDLY_FU   = 4'ha;

	localparam int unsigned PMF_TBL_DEPTH  = 4;
	localparam int unsigned PMF_TBL_PTR_W  = 2;
	localparam int unsigned PMF_FIFO_DEPTH = 8;
	localparam logic [15:0] PMF_CSUM_ZERO  = 16'h0000;

	typedef enum logic [1:0] {
		PMF_XPORT_L2,
		PMF_XPORT_IPV4,
		PMF_XPORT_IPV6
	} pmf_xport_t;

	// parsed header of one received message plus the egress checksum proposal
	typedef struct packed {
		logic [3:0]  msg_type;
		logic [3:0]  version;
		logic [7:0]  domain;
		logic [15:0] seq_id;
		logic [79:0] src_port;
		pmf_xport_t  xport;
		logic        altered;
		logic [15:0] udp_csum;
		logic [15:0] new_csum;
	} pmf_msg_t;

	typedef struct packed {
		logic        to_host;
		logic        drop;
		logic        ts_capture;
		logic        paired;
		logic [3:0]  msg_type;
		logic [15:0] seq_id;
		logic [15:0] udp_csum;
	} pmf_verdict_t;

	typedef struct packed {
		logic        valid;
		logic        peer;
		logic [7:0]  domain;
		logic [15:0] seq_id;
		logic [79:0] src_port;
	} pmf_req_entry_t;

endpackage

// [logic/pmf_fifo.sv]
// synchronous valid/ready fifo holding filter verdicts
`timescale 1ns/1ps
module pmf_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 8
) (
	// clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             ce,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic [$clog2(DEPTH):0] level
);
	localparam int unsigned PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr;
	logic [PW-1:0]    rd_ptr;
	logic [PW:0]      count;
	wire              push = in_valid & in_ready;
	wire              pop  = out_valid & out_ready & ce;

	assign in_ready  = ce & (count != (PW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data  = mem[rd_ptr];
	assign level     = count;

	always_ff @(posedge pclk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else if (ce) begin
			if (push) begin
				wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + (PW+1)'(push) - (PW+1)'(pop);
		end
	end
endmodule

// [logic/pmf_filter.sv]
// ptp message qualification, request pairing and egress checksum policy with apb registers
//
// Notes on behaviour
// - delay response paired with request goes host
// - peer responses paired with peer request go host
// - drop sync, follow up, delay request without master
// - domain check: match forwards host, mismatch drops
// - ipv4 checksum recalculated, or zeroed when off
// - zero ipv4 checksum stays zero on egress
// - ipv6 udp checksum always updated
// - version field resets two, matching messages captured
// - version mismatch drops, except exempted types
// - domain field resets zero, gates timestamp capture
// - domain ignored while domain checking off
// - reset values: checksum on, version two, others zero
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
module pmf_filter
	import pmf_pkg::*;
(
	// clock and reset
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	input  wire logic                      ce,
	// apb slave
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [PMF_ADDR_W-1:0]     paddr,
	input  wire logic [PMF_DATA_W-1:0]     pwdata,
	output logic                           pready,
	output logic [PMF_DATA_W-1:0]          prdata,
	output logic                           pslverr,
	// best master state from the clock selection logic
	input  wire logic                      best_master_selection,
	// received messages
	input  wire logic                      msg_valid,
	output logic                           msg_ready,
	input  wire pmf_pkg::pmf_msg_t         msg,
	// verdicts toward the forwarding engine
	output logic                           verdict_valid,
	input  wire logic                      verdict_ready,
	output pmf_pkg::pmf_verdict_t          verdict
);
	import pmf_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// registers
	logic [PMF_REG_W-1:0] msg_cfg2;
	logic [PMF_REG_W-1:0] dom_ver;
	logic [PMF_REG_W-1:0] ver_exc;
	logic [PMF_REG_W-1:0] drop_count;
	logic                 ack;

	wire resp_pair_en = msg_cfg2[PMF_BIT_RESP_PAIR];
	wire peer_pair_en = msg_cfg2[PMF_BIT_PEER_PAIR];
	wire drop_nobm_en = msg_cfg2[PMF_BIT_DROP_NOBM];
	wire dom_chk_en   = msg_cfg2[PMF_BIT_DOM_CHK];
	wire csum_v4_en   = msg_cfg2[PMF_BIT_CSUM_V4];
	wire [PMF_VER_W-1:0] domain_version      = dom_ver[PMF_VER_LSB +: PMF_VER_W];
	wire [PMF_DOM_W-1:0] domain_match_value  = dom_ver[PMF_DOM_LSB +: PMF_DOM_W];

	function automatic logic [PMF_ADDR_W-1:0] byte_addr(input logic [13:0] idx);
		byte_addr = {idx, 2'b00};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// apb decode
	wire                   apb_access = psel & penable & ce;
	wire                   hit_cfg2   = (paddr == byte_addr(PMF_IDX_MSG_CFG2));
	wire                   hit_dv     = (paddr == byte_addr(PMF_IDX_DOM_VER));
	wire                   hit_exc    = (paddr == byte_addr(PMF_IDX_VER_EXC));
	wire                   hit_stat   = (paddr == byte_addr(PMF_IDX_STATUS));
	wire                   hit_any    = hit_cfg2 | hit_dv | hit_exc | hit_stat;
	// the write lands on the edge where pready is seen high
	wire                   wr_take    = apb_access & ack & pwrite;
	wire                   wr_cfg2    = wr_take & hit_cfg2;
	wire                   wr_dv      = wr_take & hit_dv;
	wire                   wr_exc     = wr_take & hit_exc;
	wire [PMF_REG_W-1:0]   wdat       = pwdata[PMF_REG_W-1:0];
	wire [PMF_TBL_DEPTH-1:0] tbl_valid_vec;
	wire [PMF_REG_W-1:0]   status_word;
	wire [PMF_REG_W-1:0]   rd_mux;

	assign status_word = {drop_count[PMF_REG_W-PMF_TBL_DEPTH-1:0], tbl_valid_vec};
	assign rd_mux = hit_cfg2 ? msg_cfg2 :
	                hit_dv   ? dom_ver :
	                hit_exc  ? ver_exc :
	                hit_stat ? status_word : '0;
	assign pready = ack;

	// one wait state so the read data leaves a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack <= 1'b0;
		end else if (ce) begin
			ack <= psel & penable & ~ack;
		end
	end

	// data and error load on the same edge as ack, so all three stand together
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (ce) begin
			prdata <= {{(PMF_DATA_W-PMF_REG_W){1'b0}}, rd_mux};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else if (ce) begin
			pslverr <= psel & penable & ~ack & ~hit_any;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			msg_cfg2 <= PMF_CFG2_RST;
		end else if (wr_cfg2) begin
			msg_cfg2 <= wdat & PMF_CFG2_WMASK;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dom_ver <= PMF_DV_RST;
		end else if (wr_dv) begin
			dom_ver <= wdat & PMF_DV_WMASK;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ver_exc <= PMF_EXC_RST;
		end else if (wr_exc) begin
			ver_exc <= wdat;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// request table for pairing
	pmf_req_entry_t            tbl [PMF_TBL_DEPTH];
	logic [PMF_TBL_PTR_W-1:0]  tbl_wr_ptr;
	logic [PMF_TBL_DEPTH-1:0]  hit_vec;
	logic [PMF_TBL_PTR_W-1:0]  hit_idx;
	logic                      hit_found;

	function automatic logic entry_hit(input pmf_req_entry_t e, input logic peer, input pmf_msg_t m);
		entry_hit = e.valid && (e.peer == peer) && (e.domain == m.domain) &&
		            (e.seq_id == m.seq_id) && (e.src_port == m.src_port);
	endfunction

	// one decode for every message type compare
	function automatic logic type_is(input logic [3:0] mt, input logic [3:0] code);
		type_is = (mt == code);
	endfunction

	wire is_dly_req   = type_is(msg.msg_type, PMF_MT_DLY_REQ);
	wire is_pdly_req  = type_is(msg.msg_type, PMF_MT_PDLY_REQ);
	wire is_dly_resp  = type_is(msg.msg_type, PMF_MT_DLY_RESP);
	wire is_pdly_resp = type_is(msg.msg_type, PMF_MT_PDLY_RESP);
	wire is_pdly_fu   = type_is(msg.msg_type, PMF_MT_PDLY_FU);
	wire is_sync_grp  = type_is(msg.msg_type, PMF_MT_SYNC) | type_is(msg.msg_type, PMF_MT_FOLLOW_UP) | is_dly_req;
	wire peer_resp    = is_pdly_resp | is_pdly_fu;
	wire resp_chk     = (is_dly_resp & resp_pair_en) | (peer_resp & peer_pair_en);

	genvar gi;
	generate
		for (gi = 0; gi < PMF_TBL_DEPTH; gi++) begin : g_tbl
			assign tbl_valid_vec[gi] = tbl[gi].valid;
			assign hit_vec[gi]       = entry_hit(tbl[gi], peer_resp, msg);
		end
	endgenerate

	always_comb begin
		hit_idx   = '0;
		hit_found = 1'b0;
		for (int i = PMF_TBL_DEPTH - 1; i >= 0; i--) begin
			if (hit_vec[i]) begin
				hit_idx   = PMF_TBL_PTR_W'(i);
				hit_found = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// qualification
	wire ver_match  = (msg.version == domain_version);
	wire ver_exempt = ver_exc[msg.msg_type];
	wire ver_ok     = ver_match | ver_exempt;
	wire dom_ok     = ~dom_chk_en | (msg.domain == domain_match_value);
	wire nobm_drop  = drop_nobm_en & ~best_master_selection & is_sync_grp;
	wire pair_ok    = ~resp_chk | hit_found;
	wire drop_now   = ~ver_ok | ~dom_ok | nobm_drop;
	wire accept     = msg_valid & msg_ready;
	wire store_req  = accept & ~drop_now & ((is_dly_req & resp_pair_en) | (is_pdly_req & peer_pair_en));
	// a peer response keeps its entry so the follow up can still pair
	wire peer_resp_keep = is_pdly_resp;
	wire consume    = accept & ~drop_now & resp_chk & hit_found & ~peer_resp_keep;
	pmf_req_entry_t new_entry;

	assign new_entry = '{valid: 1'b1, peer: is_pdly_req, domain: msg.domain,
	                     seq_id: msg.seq_id, src_port: msg.src_port};

	logic [15:0]  csum_out;
	pmf_verdict_t next_verdict;

	always_comb begin
		case (msg.xport)
			PMF_XPORT_IPV6: csum_out = msg.new_csum;
			PMF_XPORT_IPV4: begin
				if (msg.udp_csum == PMF_CSUM_ZERO) begin
					csum_out = PMF_CSUM_ZERO;
				end else if (msg.altered) begin
					csum_out = csum_v4_en ? msg.new_csum : PMF_CSUM_ZERO;
				end else begin
					csum_out = msg.udp_csum;
				end
			end
			default: csum_out = msg.udp_csum;
		endcase
	end

	always_comb begin
		next_verdict            = '0;
		next_verdict.drop       = drop_now;
		next_verdict.to_host    = ~drop_now & pair_ok;
		next_verdict.ts_capture = ver_match & dom_ok;
		next_verdict.paired     = resp_chk & hit_found;
		next_verdict.msg_type   = msg.msg_type;
		next_verdict.seq_id     = msg.seq_id;
		next_verdict.udp_csum   = csum_out;
	end

	////////////////////////////////////////////////////////////////////////
	// table update
	logic [PMF_TBL_DEPTH-1:0]  ent_set;
	logic [PMF_TBL_DEPTH-1:0]  ent_clr;

	// a message is a request or a response, never both, so set and clear never meet
	genvar gj;
	generate
		for (gj = 0; gj < PMF_TBL_DEPTH; gj++) begin : g_ent
			assign ent_set[gj] = store_req & (tbl_wr_ptr == PMF_TBL_PTR_W'(gj));
			assign ent_clr[gj] = consume & (hit_idx == PMF_TBL_PTR_W'(gj));
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < PMF_TBL_DEPTH; i++) begin
				tbl[i] <= '0;
			end
			tbl_wr_ptr <= '0;
		end else if (ce) begin
			for (int i = 0; i < PMF_TBL_DEPTH; i++) begin
				if (ent_set[i]) begin
					tbl[i] <= new_entry;
				end else if (ent_clr[i]) begin
					tbl[i].valid <= 1'b0;
				end
			end
			if (store_req) begin
				tbl_wr_ptr <= tbl_wr_ptr + 1'b1;
			end
		end
	end

	wire drop_inc = accept & drop_now & (drop_count != '1);

	// saturating at all ones, but the status word carries only the low 12 bits, so software sees those wrap
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drop_count <= '0;
		end else if (drop_inc) begin
			drop_count <= drop_count + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// verdict buffer; a stalled consumer backs up into msg_ready
	pmf_fifo #(
		.WIDTH ($bits(pmf_verdict_t)),
		.DEPTH (PMF_FIFO_DEPTH)
	) u_fifo (
		.pclk      (pclk),
		.presetn   (presetn),
		.ce        (ce),
		.in_valid  (msg_valid),
		.in_ready  (msg_ready),
		.in_data   (next_verdict),
		.out_valid (verdict_valid),
		.out_ready (verdict_ready),
		.out_data  (verdict),
		.level     ()
	);
endmodule

// [tb/pmf_filter_assertions.sv]
// port-level checker for the ptp message filter
`timescale 1ns/1ps
module pmf_filter_assertions
	import pmf_pkg::*;
(
	// clock and reset
	input wire logic                  pclk,
	input wire logic                  presetn,
	input wire logic                  ce,
	// apb
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pready,
	input wire logic [PMF_DATA_W-1:0] prdata,
	input wire logic                  pslverr,
	// streams
	input wire logic                  msg_valid,
	input wire logic                  msg_ready,
	input wire logic                  verdict_valid,
	input wire logic                  verdict_ready,
	input wire pmf_pkg::pmf_verdict_t verdict
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////////////
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_wait;
		psel && penable && ce && !pready;
	endsequence
	a_apb_one_wait: assert property (s_wait |=> pready) else $error("apb answer late");
	a_apb_no_early: assert property (s_setup |=> !pready) else $error("apb answer in setup");
	a_apb_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
	a_err_no_data: assert property (pslverr |-> pready && prdata == 32'h00000000) else $error("error with data");
	a_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0000) else $error("upper half not zero");
	a_take_valid: assert property (msg_valid && msg_ready |=> verdict_valid) else $error("verdict missing");
	a_verdict_hold: assert property (verdict_valid && !verdict_ready |=> verdict_valid && $stable(verdict))
		else $error("verdict changed while stalled");
	a_drop_excl: assert property (verdict_valid |-> !(verdict.to_host && verdict.drop)) else $error("dropped to host");
	a_paired_host: assert property (verdict_valid && verdict.paired && !verdict.drop |-> verdict.to_host)
		else $error("pair not forwarded");
endmodule
bind pmf_filter pmf_filter_assertions chk_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
	.penable(penable), .pready(pready), .prdata(prdata), .pslverr(pslverr), .msg_valid(msg_valid),
	.msg_ready(msg_ready), .verdict_valid(verdict_valid), .verdict_ready(verdict_ready), .verdict(verdict));

// [tb/pmf_fwd_sink.sv]
// forwarding-engine stand-in that takes verdicts, with a stall control
`timescale 1ns/1ps
module pmf_fwd_sink (
	// reset only, no clock
	input  wire logic presetn,
	// control from the bench
	input  wire logic stall,
	// verdict handshake
	output logic      verdict_ready
);
	// held low in reset so nothing is taken before the engine is up
	assign verdict_ready = presetn && !stall;
endmodule

// [tb/tb.sv]
// self-checking bench for the ptp message filter
`timescale 1ns/1ps
module tb;
	import pmf_pkg::*;
	logic         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, bm = 1, msg_valid = 0, stall = 0;
	logic [15:0]  paddr = 16'h0000;
	logic [31:0]  pwdata = 32'h0, prdata;
	logic         pready, pslverr, msg_ready, verdict_valid, verdict_ready;
	logic         ce = 1;
	pmf_msg_t     msg = '0;
	pmf_verdict_t verdict, v;
	int           err_count = 0, checked = 0;
	localparam logic [15:0] A_CFG = {PMF_IDX_MSG_CFG2, 2'b00}, A_DV = {PMF_IDX_DOM_VER, 2'b00};
	localparam logic [15:0] A_EXC = {PMF_IDX_VER_EXC, 2'b00}, A_STAT = {PMF_IDX_STATUS, 2'b00};
	always #2.5 pclk = ~pclk;
	pmf_filter uut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.best_master_selection(bm), .msg_valid(msg_valid), .msg_ready(msg_ready), .msg(msg),
		.verdict_valid(verdict_valid), .verdict_ready(verdict_ready), .verdict(verdict));
	pmf_fwd_sink sink (.presetn(presetn), .stall(stall), .verdict_ready(verdict_ready));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d, output logic [31:0] rd,
			output logic err);
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk iff pready === 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rd_reg(input logic [15:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r, exp);
	endtask
	// one message in; waits for its verdict unless the sink is meant to stall
	task automatic snd(input logic [3:0] t, input logic [3:0] ver, input logic [7:0] dom, input logic [15:0] seq,
			input pmf_xport_t x, input logic alt, input logic [15:0] cs, input logic wait_v);
		@(posedge pclk);
		msg       <= '{t, ver, dom, seq, 80'h0a0b, x, alt, cs, 16'hbeef};
		msg_valid <= 1'b1;
		@(posedge pclk iff msg_ready === 1'b1);
		msg_valid <= 1'b0;
		if (wait_v) begin
			@(posedge pclk iff (verdict_valid === 1'b1 && verdict_ready === 1'b1));
			v = verdict;
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		logic [31:0] r;
		logic        e;
		rd_reg(A_CFG, 32'h0004);
		rd_reg(A_DV, 32'h0200);
		apb(1'b0, 16'h0004, 32'h0, r, e);
		chk(r, 32'h0);
		chk(e, 32'h1);
		wr_reg(A_CFG, 32'hffff);
		rd_reg(A_CFG, 32'h01ff);
		wr_reg(A_DV, 32'hffff);
		rd_reg(A_DV, 32'h0fff);
		wr_reg(A_DV, 32'h0205);
	endtask
	task automatic t_version();
		wr_reg(A_CFG, 32'h0004);
		snd(PMF_MT_SYNC, 4'h2, 8'h05, 16'h1, PMF_XPORT_L2, 1'b0, 16'h1234, 1'b1);
		chk({v.drop, v.ts_capture, v.udp_csum}, {2'b01, 16'h1234});
		snd(PMF_MT_SYNC, 4'h3, 8'h05, 16'h2, PMF_XPORT_L2, 1'b0, 16'h1234, 1'b1);
		chk({v.drop, v.ts_capture}, 2'b10);
		wr_reg(A_EXC, 32'h0001);
		rd_reg(A_EXC, 32'h0001);
		snd(PMF_MT_SYNC, 4'h3, 8'h05, 16'h2, PMF_XPORT_L2, 1'b0, 16'h1234, 1'b1);
		chk({v.drop, v.ts_capture, v.to_host}, 3'b001);
		wr_reg(A_EXC, 32'h0000);
	endtask
	task automatic t_nobm();
		logic [3:0] ty [3] = '{PMF_MT_SYNC, PMF_MT_FOLLOW_UP, PMF_MT_DLY_REQ};
		wr_reg(A_CFG, 32'h0024);
		bm <= 1'b0;
		foreach (ty[i]) begin
			snd(ty[i], 4'h2, 8'h05, 16'h3, PMF_XPORT_L2, 1'b0, 16'h0, 1'b1);
			chk(v.drop, 1'b1);
		end
		snd(PMF_MT_PDLY_REQ, 4'h2, 8'h05, 16'h3, PMF_XPORT_L2, 1'b0, 16'h0, 1'b1);
		chk(v.drop, 1'b0);
		bm <= 1'b1;
		snd(PMF_MT_SYNC, 4'h2, 8'h05, 16'h4, PMF_XPORT_L2, 1'b0, 16'h0, 1'b1);
		chk(v.drop, 1'b0);
	endtask
	task automatic t_domain();
		wr_reg(A_CFG, 32'h0014);
		snd(PMF_MT_SYNC, 4'h2, 8'h05, 16'h5, PMF_XPORT_L2, 1'b0, 16'h0, 1'b1);
		chk({v.drop, v.ts_capture}, 2'b01);
		snd(PMF_MT_SYNC, 4'h2, 8'h06, 16'h6, PMF_XPORT_L2, 1'b0, 16'h0, 1'b1);
		chk({v.drop, v.ts_capture}, 2'b10);
		wr_reg(A_CFG, 32'h0004);
		snd(PMF_MT_SYNC, 4'h2, 8'h06, 16'h7, PMF_XPORT_L2, 1'b0, 16'h0, 1'b1);
		chk({v.drop, v.ts_capture}, 2'b01);
	endtask
	task automatic t_pair();
		wr_reg(A_CFG, 32'h0104);
		snd(PMF_MT_DLY_REQ, 4'h2, 8'h05, 16'h7, PMF_XPORT_L2, 1'b0, 16'h0, 1'b1);
		snd(PMF_MT_DLY_RESP, 4'h2, 8'h05, 16'h7, PMF_XPORT_L2, 1'b0, 16'h0, 1'b1);
		chk({v.to_host, v.paired}, 2'b11);
		chk(v.msg_type, PMF_MT_DLY_RESP);
		// the first answer used the entry up, so a repeat has nothing to pair with
		snd(PMF_MT_DLY_RESP, 4'h2, 8'h05, 16'h7, PMF_XPORT_L2, 1'b0, 16'h0, 1'b1);
		chk({v.to_host, v.paired}, 2'b00);
		wr_reg(A_CFG, 32'h0084);
		snd(PMF_MT_PDLY_REQ, 4'h2, 8'h05, 16'h9, PMF_XPORT_L2, 1'b0, 16'h0, 1'b1);
		snd(PMF_MT_PDLY_RESP, 4'h2, 8'h05, 16'h9, PMF_XPORT_L2, 1'b0, 16'h0, 1'b1);
		chk({v.to_host, v.paired}, 2'b11);
		// five drops so far, and only the peer request entry still held
		rd_reg(A_STAT, 32'h0052);
		snd(PMF_MT_PDLY_FU, 4'h2, 8'h05, 16'h9, PMF_XPORT_L2, 1'b0, 16'h0, 1'b1);
		chk({v.to_host, v.paired}, 2'b11);
	endtask
	task automatic t_csum();
		wr_reg(A_CFG, 32'h0004);
		snd(PMF_MT_SYNC, 4'h2, 8'h05, 16'ha, PMF_XPORT_IPV4, 1'b1, 16'h1234, 1'b1);
		chk(v.udp_csum, 16'hbeef);
		snd(PMF_MT_SYNC, 4'h2, 8'h05, 16'hb, PMF_XPORT_IPV4, 1'b1, 16'h0000, 1'b1);
		chk(v.udp_csum, 16'h0000);
		wr_reg(A_CFG, 32'h0000);
		snd(PMF_MT_SYNC, 4'h2, 8'h05, 16'hc, PMF_XPORT_IPV4, 1'b1, 16'h1234, 1'b1);
		chk(v.udp_csum, 16'h0000);
		snd(PMF_MT_SYNC, 4'h2, 8'h05, 16'hd, PMF_XPORT_IPV6, 1'b1, 16'h1234, 1'b1);
		chk(v.udp_csum, 16'hbeef);
	endtask
	task automatic t_fifo();
		stall <= 1'b1;
		ce    <= 1'b0;
		@(posedge pclk);
		chk(msg_ready, 1'b0);
		ce    <= 1'b1;
		for (int i = 0; i < 8; i++)
			snd(PMF_MT_SYNC, 4'h2, 8'h05, 16'(i), PMF_XPORT_L2, 1'b0, 16'h0, 1'b0);
		@(posedge pclk);
		chk(msg_ready, 1'b0);
		stall <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			@(posedge pclk iff (verdict_valid === 1'b1 && verdict_ready === 1'b1));
			chk(verdict.seq_id, 16'(i));
		end
		@(posedge pclk);
		chk(verdict_valid, 1'b0);
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic final_report();
		if (err_count == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_version();
		t_nobm();
		t_domain();
		t_pair();
		t_csum();
		t_fifo();
		final_report();
	end
	// the whole sequence needs well under a thousand cycles
	initial begin
		repeat (20000) @(posedge pclk);
		err_count++;
		final_report();
	end
endmodule
